// *** rtl/mtp_pkg.sv ***
/*
 * constants shared by the page program sequencer: link framing, block
 * codes, page geometry, locked pages, soft reset location, write timing.
 * assumes a 125 mhz core clock and an i2c host on the serial pins.
 */
package mtp_pkg;
    // core clock period
    localparam int CLK_PERIOD_NS = 8;
    // max_write_cycle_time, plain default in microseconds
    localparam int MAX_WRITE_CYCLE_TIME_US = 20;
    // least time, so rounded up to whole cycles
    localparam int WRITE_CYCLES =
        (MAX_WRITE_CYCLE_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [11:0] WRITE_CYCLES_W = 12'(WRITE_CYCLES);
    // upper nibble of the control byte; value is arbitrary
    localparam logic [3:0] DEV_CODE = 4'h8;
    // block address field of the control byte
    localparam logic [2:0] BLK_REG = 3'h0;
    localparam logic [2:0] BLK_NVM = 3'h2;
    localparam logic [2:0] BLK_EE = 3'h3;
    localparam logic [2:0] BLK_ERASE = 3'h4;
    // erase selector byte: space bit above the page nibble
    localparam int ERASE_SPACE_BIT = 4;
    // page geometry
    localparam logic [4:0] PAGE_BYTES = 5'h10;
    localparam int PAGE_LEN = 16;
    localparam int SPACE_BYTES = 256;
    // factory locked service pages of the configuration space
    localparam logic [3:0] SVC_PAGE_A = 4'h8;
    localparam logic [3:0] SVC_PAGE_B = 4'hf;
    // soft reset bit location in the register space
    localparam logic [7:0] SOFT_RESET_ADDR = 8'h7b;
    localparam int SOFT_RESET_BIT = 0;
    // byte phase within one transaction
    localparam logic [1:0] PH_CTRL = 2'h0;
    localparam logic [1:0] PH_ADDR = 2'h1;
    localparam logic [1:0] PH_DATA = 2'h2;
    // staging fifo between link and programming engine
    localparam int FIFO_WIDTH = 12;
    localparam int FIFO_DEPTH = 8;
    // link state machine
    typedef enum logic [2:0] {
        ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_TXACK
    } link_state_e;
endpackage

// *** rtl/mtp_page_program_sequencer.sv ***
/*
 * holds the staging fifo and the page program sequencer: an i2c target
 * that takes page writes, page erases and reads into two nonvolatile
 * spaces and keeps the working configuration copy.
 * assumes scl and sda arrive asynchronously and much slower than the core
 * clock; the open-drain wire is resolved outside.
 */
// Behaviour
// RL1 - program writes limited to one 16-byte page
// RL2 - programming only sets bits; erase clears
// RL3 - host programs each byte once per erase; t_cfg programs byte 00 twice per erase
// RL4 - function reads the volatile working copy
// RL5 - reload only on reset or soft reset
// RL6 - host preserves tolerance bytes of page 14
// RL7 - fixed wait and ack polling both work
// RL8 - non-polling host waits max write time
// RL9 - address ack returns as cycle ends
// RL10 - eeprom block 011, configuration block 010
// RL11 - all sixteen eeprom pages writable, erasable
// RL12 - eeprom flow needs no tolerance preservation
// RL13 - configuration pages 8 and 15 locked
// RL14 - soft reset bit 984 reloads working copy; code skips the reload while FULL_WRITE_PROTECT_I is high
// RL15 - host erases, writes, reads back, compares
// RL16 - no address ack while cycle runs
`timescale 1ns/1ps

module mtp_stage_fifo #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_reg [DEPTH]; // entry storage
    logic [AW-1:0] wr_ptr_reg; // next slot to fill
    logic [AW-1:0] rd_ptr_reg; // next slot to drain
    logic [AW:0] count_reg; // occupancy
    logic push; // accepted write
    logic pop; // accepted read

    assign in_ready_o = (count_reg != (AW+1)'(DEPTH));
    assign out_valid_o = (count_reg != '0);
    assign out_data_o = mem_reg[rd_ptr_reg];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;

    // storage write, no reset needed on data
    always_ff @(posedge clk_i) begin
        if (push) begin
            mem_reg[wr_ptr_reg] <= in_data_i;
        end
    end

    // pointers and count
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
            end
            if (push && !pop) begin
                count_reg <= count_reg + 1'b1;
            end else if (pop && !push) begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end
endmodule // mtp_stage_fifo

module mtp_page_program_sequencer (
    input wire logic CLOCK_I,
    input wire logic RST_I,
    input wire logic SCL_I,
    input wire logic SDA_I,
    output logic SDA_O,
    output logic SDA_OE_N_O,
    input wire logic FULL_WRITE_PROTECT_I,
    input wire logic [7:0] CFG_ADDR_I,
    output logic [7:0] CFG_DATA_O,
    output logic BUSY_O
);
    ////////////////////////////////////////////////////////////////////////
    // declarations
    logic scl_meta_reg, scl_s_reg, scl_d_reg; // scl synchroniser, history
    logic sda_meta_reg, sda_s_reg, sda_d_reg; // sda synchroniser, history
    logic scl_rise, scl_fall, start_evt, stop_evt; // link events
    mtp_pkg::link_state_e state_reg; // link state
    logic [3:0] bit_cnt_reg; // bits within byte
    logic [7:0] shift_reg; // received byte
    logic [7:0] tx_reg; // byte being sent
    logic [1:0] phase_reg; // which byte of the frame
    logic rw_reg; // read transaction
    logic [2:0] blk_reg; // block address of the frame
    logic [7:0] addr_reg; // word address pointer
    logic [4:0] wr_cnt_reg; // data bytes queued this frame
    logic ack_reg; // ack given or received
    logic oe_n_reg; // low while pulling sda low
    logic erase_req_reg; // erase queued for the stop
    logic [4:0] erase_sel_reg; // space and page to erase
    logic byte_ok; // current byte will be acked
    logic locked_page; // addressed config page is locked
    logic byte_done; // eighth bit just ended
    logic push_valid, push_ready, reg_wr; // data byte actions
    logic [7:0] rd_byte; // byte to send on read
    logic [7:0] nvm_mem [2*mtp_pkg::SPACE_BYTES]; // both spaces
    logic [7:0] work_mem [mtp_pkg::SPACE_BYTES]; // working copy
    logic reload_reg; // copy nvm into working copy next edge
    logic busy_reg; // internal erase or write cycle
    logic [11:0] cyc_cnt_reg; // cycle time left
    logic prog_pend_reg; // page write waits for fifo to drain
    logic prog_space_reg; // target space of page write
    logic [3:0] prog_page_reg; // target page of page write
    logic [7:0] page_buf_reg [mtp_pkg::PAGE_LEN]; // assembled page
    logic [15:0] mark_reg; // bytes present in the page buffer
    logic fifo_out_valid, fifo_pop; // drain side
    logic [11:0] fifo_out_data; // offset and data
    logic commit, erase_go; // start of a cycle
    logic wr_blk; // frame aims at a programmable space
    logic sdo_reg; // data level driven on sda

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers; first stage feeds only the second
    always_ff @(posedge CLOCK_I) begin
        scl_meta_reg <= SCL_I;
        scl_s_reg <= scl_meta_reg;
        scl_d_reg <= scl_s_reg;
        sda_meta_reg <= SDA_I;
        sda_s_reg <= sda_meta_reg;
        sda_d_reg <= sda_s_reg;
    end

    assign scl_rise = scl_s_reg && !scl_d_reg;
    assign scl_fall = !scl_s_reg && scl_d_reg;
    assign start_evt = scl_s_reg && scl_d_reg && !sda_s_reg && sda_d_reg;
    assign stop_evt = scl_s_reg && scl_d_reg && sda_s_reg && !sda_d_reg;
    assign byte_done = (state_reg == mtp_pkg::ST_RX) && scl_fall
        && (bit_cnt_reg == 4'h8);
    assign wr_blk = (blk_reg == mtp_pkg::BLK_NVM)
        || (blk_reg == mtp_pkg::BLK_EE); // see RL10

    ////////////////////////////////////////////////////////////////////////
    // byte acceptance and read data
    always_comb begin
        locked_page = (addr_reg[7:4] == mtp_pkg::SVC_PAGE_A)
            || (addr_reg[7:4] == mtp_pkg::SVC_PAGE_B);
        byte_ok = 1'b0;
        case (phase_reg)
            mtp_pkg::PH_CTRL: begin
                // busy or pending cycle withholds the address ack
                byte_ok = (shift_reg[7:4] == mtp_pkg::DEV_CODE)
                    && !busy_reg && !prog_pend_reg; // see RL16, RL9
                if (shift_reg[3:1] == mtp_pkg::BLK_ERASE) begin
                    byte_ok = byte_ok && !shift_reg[0];
                end else if (shift_reg[3:1] != mtp_pkg::BLK_REG
                    && shift_reg[3:1] != mtp_pkg::BLK_NVM
                    && shift_reg[3:1] != mtp_pkg::BLK_EE) begin
                    byte_ok = 1'b0; // see RL10
                end
            end
            mtp_pkg::PH_ADDR: begin
                // erase selector; eeprom pages never locked
                byte_ok = (blk_reg != mtp_pkg::BLK_ERASE)
                    || shift_reg[mtp_pkg::ERASE_SPACE_BIT]
                    || ((shift_reg[3:0] != mtp_pkg::SVC_PAGE_A)
                    && (shift_reg[3:0] != mtp_pkg::SVC_PAGE_B)); // see RL13, RL11
            end
            default: begin
                if (blk_reg == mtp_pkg::BLK_REG) begin
                    byte_ok = 1'b1;
                end else if (wr_blk) begin
                    // one page per write, no locked config page
                    byte_ok = (wr_cnt_reg < mtp_pkg::PAGE_BYTES) && push_ready
                        && !(blk_reg == mtp_pkg::BLK_NVM && locked_page); // see RL1, RL13
                end
            end
        endcase
        // nvm reads from array, block 000 from copy
        case (blk_reg)
            mtp_pkg::BLK_NVM: rd_byte = nvm_mem[{1'b0, addr_reg}];
            mtp_pkg::BLK_EE: rd_byte = nvm_mem[{1'b1, addr_reg}];
            default: rd_byte = work_mem[addr_reg];
        endcase
    end

    assign push_valid = byte_done && (phase_reg == mtp_pkg::PH_DATA)
        && wr_blk && byte_ok;
    assign reg_wr = byte_done && (phase_reg == mtp_pkg::PH_DATA)
        && (blk_reg == mtp_pkg::BLK_REG);

    ////////////////////////////////////////////////////////////////////////
    // link state machine
    always_ff @(posedge CLOCK_I) begin
        if (RST_I) begin
            state_reg <= mtp_pkg::ST_IDLE;
            bit_cnt_reg <= 4'h0;
            shift_reg <= 8'h00;
            tx_reg <= 8'h00;
            phase_reg <= mtp_pkg::PH_CTRL;
            rw_reg <= 1'b0;
            blk_reg <= mtp_pkg::BLK_REG;
            addr_reg <= 8'h00;
            wr_cnt_reg <= 5'h00;
            ack_reg <= 1'b0;
            oe_n_reg <= 1'b1;
            erase_req_reg <= 1'b0;
            erase_sel_reg <= 5'h00;
        end else if (start_evt || stop_evt) begin
            // start or stop ends any byte
            state_reg <= start_evt ? mtp_pkg::ST_RX : mtp_pkg::ST_IDLE;
            bit_cnt_reg <= 4'h0;
            phase_reg <= mtp_pkg::PH_CTRL;
            oe_n_reg <= 1'b1;
            wr_cnt_reg <= 5'h00;
            erase_req_reg <= 1'b0;
        end else begin
            case (state_reg)
                mtp_pkg::ST_RX: begin
                    if (scl_rise) begin
                        shift_reg <= {shift_reg[6:0], sda_s_reg};
                        bit_cnt_reg <= bit_cnt_reg + 4'h1;
                    end else if (byte_done) begin
                        ack_reg <= byte_ok;
                        oe_n_reg <= !byte_ok;
                        state_reg <= mtp_pkg::ST_ACK;
                        if (phase_reg == mtp_pkg::PH_CTRL && byte_ok) begin
                            rw_reg <= shift_reg[0];
                            blk_reg <= shift_reg[3:1];
                        end else if (phase_reg == mtp_pkg::PH_ADDR) begin
                            addr_reg <= shift_reg;
                            erase_sel_reg <= shift_reg[4:0];
                            erase_req_reg <= byte_ok
                                && (blk_reg == mtp_pkg::BLK_ERASE);
                        end else if (push_valid) begin
                            wr_cnt_reg <= wr_cnt_reg + 5'h01;
                        end else if (reg_wr) begin
                            addr_reg <= addr_reg + 8'h01;
                        end
                    end
                end
                mtp_pkg::ST_ACK: begin
                    if (scl_fall) begin
                        bit_cnt_reg <= 4'h0;
                        if (!ack_reg) begin
                            oe_n_reg <= 1'b1;
                            state_reg <= mtp_pkg::ST_IDLE;
                        end else if (phase_reg == mtp_pkg::PH_CTRL && rw_reg) begin
                            tx_reg <= rd_byte;
                            oe_n_reg <= rd_byte[7];
                            addr_reg <= addr_reg + 8'h01;
                            state_reg <= mtp_pkg::ST_TX;
                        end else begin
                            oe_n_reg <= 1'b1;
                            phase_reg <= (phase_reg == mtp_pkg::PH_CTRL)
                                ? mtp_pkg::PH_ADDR : mtp_pkg::PH_DATA;
                            state_reg <= mtp_pkg::ST_RX;
                        end
                    end
                end
                mtp_pkg::ST_TX: begin
                    if (scl_fall) begin
                        if (bit_cnt_reg == 4'h7) begin
                            oe_n_reg <= 1'b1;
                            state_reg <= mtp_pkg::ST_TXACK;
                        end else begin
                            tx_reg <= {tx_reg[6:0], 1'b0};
                            oe_n_reg <= tx_reg[6];
                            bit_cnt_reg <= bit_cnt_reg + 4'h1;
                        end
                    end
                end
                mtp_pkg::ST_TXACK: begin
                    if (scl_rise) begin
                        ack_reg <= !sda_s_reg;
                    end else if (scl_fall) begin
                        // host nack ends the read
                        bit_cnt_reg <= 4'h0;
                        if (ack_reg) begin
                            tx_reg <= rd_byte;
                            oe_n_reg <= rd_byte[7];
                            addr_reg <= addr_reg + 8'h01;
                            state_reg <= mtp_pkg::ST_TX;
                        end else begin
                            state_reg <= mtp_pkg::ST_IDLE;
                        end
                    end
                end
                default: begin
                    state_reg <= mtp_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // sda only ever pulled low; level flop kept at zero
    always_ff @(posedge CLOCK_I) begin
        sdo_reg <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // staging fifo; fills from the link, drains into the page buffer
    mtp_stage_fifo #(
        .WIDTH(mtp_pkg::FIFO_WIDTH),
        .DEPTH(mtp_pkg::FIFO_DEPTH)
    ) u_stage (
        .clk_i(CLOCK_I),
        .rst_i(RST_I),
        .in_valid_i(push_valid),
        .in_ready_o(push_ready),
        .in_data_i({addr_reg[3:0] + wr_cnt_reg[3:0], shift_reg}),
        .out_valid_o(fifo_out_valid),
        .out_ready_i(!busy_reg),
        .out_data_o(fifo_out_data)
    );

    assign fifo_pop = fifo_out_valid && !busy_reg;
    assign commit = prog_pend_reg && !fifo_out_valid && !busy_reg;
    assign erase_go = stop_evt && erase_req_reg && !busy_reg;

    ////////////////////////////////////////////////////////////////////////
    // page buffer; a cycle drains it, so no wrap over frames
    always_ff @(posedge CLOCK_I) begin
        if (RST_I || commit) begin
            mark_reg <= 16'h0000;
        end else if (fifo_pop) begin
            page_buf_reg[fifo_out_data[11:8]] <= fifo_out_data[7:0];
            mark_reg[fifo_out_data[11:8]] <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // cycle engine: queue, start and time erase and page write
    always_ff @(posedge CLOCK_I) begin
        if (RST_I) begin
            busy_reg <= 1'b0;
            cyc_cnt_reg <= 12'h000;
            prog_pend_reg <= 1'b0;
            prog_space_reg <= 1'b0;
            prog_page_reg <= 4'h0;
        end else if (busy_reg) begin
            // ack returns on the same edge the count reaches zero
            cyc_cnt_reg <= cyc_cnt_reg - 12'h001;
            busy_reg <= (cyc_cnt_reg != 12'h001); // see RL9, RL7
        end else if (erase_go || commit) begin
            busy_reg <= 1'b1;
            cyc_cnt_reg <= mtp_pkg::WRITE_CYCLES_W; // see RL16
            prog_pend_reg <= 1'b0;
        end else if (stop_evt && wr_blk && wr_cnt_reg != 5'h00
            && phase_reg == mtp_pkg::PH_DATA) begin
            prog_pend_reg <= 1'b1;
            prog_space_reg <= (blk_reg == mtp_pkg::BLK_EE);
            prog_page_reg <= addr_reg[7:4];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // nonvolatile arrays; programming only raises bits
    always_ff @(posedge CLOCK_I) begin
        for (int i = 0; i < mtp_pkg::PAGE_LEN; i++) begin
            if (erase_go) begin
                nvm_mem[{erase_sel_reg, 4'(i)}] <= 8'h00; // see RL2, RL11
            end else if (commit && mark_reg[i]) begin
                nvm_mem[{prog_space_reg, prog_page_reg, 4'(i)}] <=
                    nvm_mem[{prog_space_reg, prog_page_reg, 4'(i)}]
                    | page_buf_reg[i]; // see RL2, RL3
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // reload request: reset, or soft reset bit unless fully write locked
    always_ff @(posedge CLOCK_I) begin
        if (RST_I) begin
            reload_reg <= 1'b1; // see RL5
        end else begin
            reload_reg <= reg_wr && (addr_reg == mtp_pkg::SOFT_RESET_ADDR)
                && shift_reg[mtp_pkg::SOFT_RESET_BIT]
                && !FULL_WRITE_PROTECT_I; // see RL14, RL5
        end
    end

    // working copy; new nvm content shows only after a reload
    always_ff @(posedge CLOCK_I) begin
        if (reload_reg) begin
            for (int i = 0; i < mtp_pkg::SPACE_BYTES; i++) begin
                work_mem[i] <= nvm_mem[i]; // see RL5
            end
        end else if (reg_wr) begin
            work_mem[addr_reg] <= shift_reg;
        end
    end

    // function sees the working copy only
    always_ff @(posedge CLOCK_I) begin
        if (RST_I) begin
            CFG_DATA_O <= 8'h00;
        end else begin
            CFG_DATA_O <= work_mem[CFG_ADDR_I]; // see RL4
        end
    end

    assign SDA_O = sdo_reg;
    assign SDA_OE_N_O = oe_n_reg;
    assign BUSY_O = busy_reg;
endmodule // mtp_page_program_sequencer

// *** bench/i2c_host_model.sv ***
/* i2c host model, the in-system programmer.
   assumes the bench resolves sda with a pull-up. */
`timescale 1ns/1ps
module i2c_host_model (
    input wire logic clk_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_o
);
    // bus idles with both lines high
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end
    ////////////////////////////////////////
    // half of the 80 ns link period
    task automatic half();
        repeat (5) @(negedge clk_i);
    endtask
    // start, also repeated
    task automatic start();
        @(negedge clk_i);
        sda_o = 1'b1;
        half();
        scl_o = 1'b1;
        half();
        sda_o = 1'b0;
        half();
        scl_o = 1'b0;
    endtask
    // stop; scl then stands still
    task automatic stop();
        @(negedge clk_i);
        sda_o = 1'b0;
        half();
        scl_o = 1'b1;
        half();
        sda_o = 1'b1;
        half();
    endtask
    // sda moves a clock after scl falls: no false start
    task automatic bit_x(input logic b, output logic r);
        @(negedge clk_i);
        sda_o = b;
        half();
        scl_o = 1'b1;
        half();
        r = sda_i;
        scl_o = 1'b0;
    endtask
    // eight bits and ack slot; last=1 releases sda
    task automatic xfer(input logic [7:0] d, input logic last,
                        output logic [7:0] q, output logic nak);
        for (int i = 7; i >= 0; i--) begin
            bit_x(d[i], q[i]);
        end
        bit_x(last, nak);
    endtask
endmodule // i2c_host_model

// *** bench/mtp_seq_checker_properties.sv ***
/* concurrent checks on the sequencer top ports.
   assumes the core clock, sync active-high reset. */
`timescale 1ns/1ps
module mtp_seq_checker (
    input wire logic CLOCK_I,
    input wire logic RST_I,
    input wire logic SCL_I,
    input wire logic SDA_I,
    input wire logic SDA_O,
    input wire logic SDA_OE_N_O,
    input wire logic FULL_WRITE_PROTECT_I,
    input wire logic [7:0] CFG_ADDR_I,
    input wire logic [7:0] CFG_DATA_O,
    input wire logic BUSY_O
);
    default clocking @(posedge CLOCK_I); endclocking
    default disable iff (RST_I);
    logic [11:0] busy_cnt_reg; // cycles busy has been up
    logic [3:0] scl_hi_reg; // cycles scl rested high, saturating
    ////////////////////////////////////////
    // internal cycle length at the pin
    always_ff @(posedge CLOCK_I) begin
        if (RST_I || !BUSY_O) busy_cnt_reg <= 12'h000;
        else busy_cnt_reg <= busy_cnt_reg + 12'h001;
    end
    // idle bus, raw pin covers sync lag
    always_ff @(posedge CLOCK_I) begin
        if (RST_I || !SCL_I) scl_hi_reg <= 4'h0;
        else if (scl_hi_reg != 4'hf) scl_hi_reg <= scl_hi_reg + 4'h1;
    end
    // an ack or zero bit is held a while
    sequence s_ack_held;
        !SDA_OE_N_O [*4];
    endsequence
    ////////////////////////////////////////
    AST_RESET_QUIET: assert property (disable iff (1'b0)
        RST_I |=> SDA_OE_N_O && !BUSY_O && CFG_DATA_O == 8'h00)
        else $error("outputs not quiet after reset");
    AST_BUSY_LEN: assert property (
        $fell(BUSY_O) |-> busy_cnt_reg == mtp_pkg::WRITE_CYCLES_W)
        else $error("write cycle length wrong");
    AST_NO_ACK_BUSY: assert property (
        BUSY_O |-> SDA_OE_N_O)
        else $error("sda pulled during internal cycle");
    AST_CFG_HOLD: assert property (
        BUSY_O && $past(BUSY_O) && $past(CFG_ADDR_I) == $past(CFG_ADDR_I, 2)
        |-> $stable(CFG_DATA_O))
        else $error("working copy moved during programming");
    AST_EDGE_SCL_LOW: assert property (
        $changed(SDA_OE_N_O) |-> !SCL_I)
        else $error("sda changed while scl high");
    AST_ACK_STANDS: assert property (
        $fell(SDA_OE_N_O) |-> s_ack_held)
        else $error("ack released too early");
    AST_IDLE_RELEASED: assert property (
        scl_hi_reg >= 4'ha |-> SDA_OE_N_O)
        else $error("sda pulled on idle bus");
    AST_OPEN_DRAIN: assert property (
        !SDA_OE_N_O |-> !SDA_O)
        else $error("sda driven high");
endmodule // mtp_seq_checker

bind mtp_page_program_sequencer mtp_seq_checker i_chk (
    .CLOCK_I(CLOCK_I), .RST_I(RST_I), .SCL_I(SCL_I), .SDA_I(SDA_I),
    .SDA_O(SDA_O), .SDA_OE_N_O(SDA_OE_N_O), .BUSY_O(BUSY_O),
    .FULL_WRITE_PROTECT_I(FULL_WRITE_PROTECT_I),
    .CFG_ADDR_I(CFG_ADDR_I), .CFG_DATA_O(CFG_DATA_O));

// *** bench/testbench.sv ***
/* top bench: host model, scenarios, verdict.
   assumes a pull-up on sda, modelled by the wire. */
`timescale 1ns/1ps
module testbench;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic wp = 1'b0; // full write protect
    logic [7:0] cfg_addr = 8'h00;
    logic scl, host_sda, sda_o, sda_oe_n, busy;
    logic [7:0] cfg_data;
    int errors = 0;
    int n_checks = 0;
    // open-drain wire, low if anyone pulls
    wire logic sda = host_sda & (sda_oe_n | sda_o);
    always #4 clk = ~clk;
    i2c_host_model i_host (.clk_i(clk), .sda_i(sda), .scl_o(scl),
        .sda_o(host_sda));
    mtp_page_program_sequencer i_dut (.CLOCK_I(clk), .RST_I(rst),
        .SCL_I(scl), .SDA_I(sda), .SDA_O(sda_o), .SDA_OE_N_O(sda_oe_n),
        .FULL_WRITE_PROTECT_I(wp), .CFG_ADDR_I(cfg_addr),
        .CFG_DATA_O(cfg_data), .BUSY_O(busy));
    ////////////////////////////////////////
    task automatic summarize();
        if (errors == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // start and control byte; nak = refused
    task automatic ctrl(input logic [2:0] blk, input logic rw,
                        output logic nak);
        logic [7:0] q;
        i_host.start();
        i_host.xfer({mtp_pkg::DEV_CODE, blk, rw}, 1'b1, q, nak);
    endtask
    // write n bytes base+k at a; nak of last
    task automatic wpage(input logic [2:0] blk, input logic [7:0] a,
        input int n, input logic [7:0] base, output logic nak);
        logic [7:0] q;
        ctrl(blk, 1'b0, nak);
        i_host.xfer(a, 1'b1, q, nak);
        for (int k = 0; k < n; k++) begin
            i_host.xfer(base + 8'(k), 1'b1, q, nak);
        end
        i_host.stop();
    endtask
    // read back n bytes, expect base+k
    task automatic rd_chk(input logic [2:0] blk, input logic [7:0] a,
        input int n, input logic [7:0] base);
        logic [7:0] q;
        logic nk;
        ctrl(blk, 1'b0, nk);
        i_host.xfer(a, 1'b1, q, nk);
        ctrl(blk, 1'b1, nk);
        for (int k = 0; k < n; k++) begin
            i_host.xfer(8'hff, k == n - 1, q, nk);
            check(q, base + 8'(k));
        end
        i_host.stop();
    endtask
    task automatic erase(input logic sp, input logic [3:0] pg,
                         output logic nak);
        logic [7:0] q;
        ctrl(mtp_pkg::BLK_ERASE, 1'b0, nak);
        i_host.xfer({3'h0, sp, pg}, 1'b1, q, nak);
        i_host.stop();
    endtask
    // finish by ack polling or fixed wait
    task automatic finish_op(input logic use_poll);
        int n;
        logic nk;
        n = 0;
        nk = 1'b1;
        if (use_poll) begin
            while (nk && n < 80) begin
                ctrl(mtp_pkg::BLK_EE, 1'b0, nk);
                i_host.stop();
                n++;
            end
            check(8'(n > 1), 8'h01);
            check(nk, 1'b0);
        end else begin
            repeat (mtp_pkg::WRITE_CYCLES + 40) @(negedge clk);
        end
        check(busy, 1'b0);
    endtask
    ////////////////////////////////////////
    // eeprom page, no tolerance bytes kept
    task automatic t_ee(input logic [3:0] pg, input logic use_poll);
        logic nk;
        erase(1'b1, pg, nk);
        check(nk, 1'b0);
        finish_op(use_poll);
        wpage(mtp_pkg::BLK_EE, {pg, 4'h0}, 17, {pg, 4'h1}, nk);
        check(nk, 1'b1);
        finish_op(use_poll);
        rd_chk(mtp_pkg::BLK_EE, {pg, 4'h0}, 16, {pg, 4'h1});
    endtask
    // locked pages, bit-set writes, reload
    task automatic t_cfg();
        logic nk;
        erase(1'b0, mtp_pkg::SVC_PAGE_A, nk);
        check(nk, 1'b1);
        erase(1'b0, mtp_pkg::SVC_PAGE_B, nk);
        check(nk, 1'b1);
        wpage(mtp_pkg::BLK_NVM, 8'hf3, 1, 8'h01, nk);
        check(nk, 1'b1);
        wpage(mtp_pkg::BLK_REG, 8'h00, 1, 8'h11, nk);
        erase(1'b0, 4'h0, nk);
        finish_op(1'b1);
        wpage(mtp_pkg::BLK_NVM, 8'h00, 1, 8'h5a, nk);
        finish_op(1'b0);
        // reprogram without erase, on purpose
        wpage(mtp_pkg::BLK_NVM, 8'h00, 1, 8'h0f, nk);
        finish_op(1'b1);
        rd_chk(mtp_pkg::BLK_NVM, 8'h00, 1, 8'h5f);
        check(cfg_data, 8'h11);
        wp = 1'b1;
        wpage(mtp_pkg::BLK_REG, mtp_pkg::SOFT_RESET_ADDR, 1, 8'h01, nk);
        repeat (4) @(negedge clk);
        check(cfg_data, 8'h11);
        wp = 1'b0;
        wpage(mtp_pkg::BLK_REG, mtp_pkg::SOFT_RESET_ADDR, 1, 8'h01, nk);
        repeat (4) @(negedge clk);
        check(cfg_data, 8'h5f);
    endtask
    ////////////////////////////////////////
    initial begin
        repeat (12) @(negedge clk);
        rst = 1'b0;
        repeat (4) @(negedge clk);
        t_ee(mtp_pkg::SVC_PAGE_A, 1'b1);
        t_ee(mtp_pkg::SVC_PAGE_B, 1'b0);
        t_cfg();
        summarize();
    end
    // watchdog, about two and a half times the expected run
    initial begin
        #600000;
        errors++;
        summarize();
    end
endmodule // testbench
